/* rtl/scb_top.sv */
// serial control block: avalon register slave, flags and the link-side shifter
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`include "scb_regs.svh"
module scb_top (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic [`SCB_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  output logic                        irq,
  input  wire logic                   link_clk,
  input  wire logic                   sdi,
  input  wire logic                   sel_in_n,
  output logic                        sdo,
  output logic                        sdo_oe,
  output logic                        sel_out_n,
  output logic                        sel_out_oe
);
  scb_pkg::scb_core_t st;
  scb_pkg::scb_core_t next_st;
  scb_xfer_if         xfer ();

  logic               acc;
  logic               wr_acc;
  logic               rd_acc;
  logic               done_evt;
  logic               rx_read;
  logic [7:0]         ctrl_view;

  // control register image; reserved bits read as zero
  function automatic logic [7:0] ctrl_image(input scb_pkg::scb_core_t s);
    logic [7:0] v;
    v                   = `SCB_CTRL_RESET;
    v[`SCB_BIT_IRQ_EN]  = s.irq_en;
    v[`SCB_BIT_TRANSMIT_OUTPUT_ENABLE]    = s.transmit_output_enable;
    v[`SCB_BIT_MASTER]  = s.master;
    v[`SCB_BIT_DONE]    = s.done_flag;
    v[`SCB_BIT_OVERRUN] = s.overrun;
    return v;
  endfunction

  // a request is answered in the cycle after it is first seen
  assign acc       = (avs_read || avs_write) && st.waitreq;
  assign wr_acc    = acc && avs_write && avs_byteenable[0];
  assign rd_acc    = acc && avs_read;
  assign done_evt  = st.done_sync[2] != st.done_sync[1];
  assign rx_read   = rd_acc && (avs_address == `SCB_OFS_RXBUF);
  assign ctrl_view = ctrl_image(st);

  always_comb begin
    next_st           = st;
    next_st.done_sync = {st.done_sync[1:0], xfer.done_tgl};
    next_st.busy_sync = {st.busy_sync[0], xfer.busy};
    next_st.waitreq   = !acc;

    // a short core reset is stretched so the slower link clock surely sees it
    next_st.rst_hold     = (st.rst_hold != 8'h00) ? st.rst_hold - 8'h01 : 8'h00;
    next_st.link_rst_req = (st.rst_hold != 8'h00);
    // link side is unknown until its reset lands, so its handshakes are ignored meanwhile
    if (st.link_rst_req) begin
      next_st.done_sync = 3'h0;
      next_st.busy_sync = 2'h0;
    end

    // register reads
    if (rd_acc) begin
      if (avs_address == `SCB_OFS_CTRL) begin
        next_st.rdata = {24'h000000, ctrl_view};
      end else if (avs_address == `SCB_OFS_RXBUF) begin
        next_st.rdata = {24'h000000, st.rx_buf};
      end else if (avs_address == `SCB_OFS_TXBUF) begin
        next_st.rdata = {24'h000000, st.tx_buf};
      end else if (avs_address == `SCB_OFS_CFG) begin
        next_st.rdata = {30'h00000000, st.busy_sync[1], st.soft_rst};
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end

    // register writes; unmapped addresses are acknowledged and ignored
    if (wr_acc) begin
      if (avs_address == `SCB_OFS_CTRL) begin
        next_st.irq_en = avs_writedata[`SCB_BIT_IRQ_EN];
        next_st.transmit_output_enable   = avs_writedata[`SCB_BIT_TRANSMIT_OUTPUT_ENABLE];
        next_st.master = avs_writedata[`SCB_BIT_MASTER];
      end else if (avs_address == `SCB_OFS_TXBUF) begin
        next_st.tx_buf = avs_writedata[7:0];
        if (st.master) begin
          next_st.start_tgl = ~st.start_tgl;
        end
      end else if (avs_address == `SCB_OFS_CFG) begin
        next_st.soft_rst = avs_writedata[`SCB_BIT_SOFT_RST];
      end
    end

    // receive buffer read clears both flags
    if (rx_read) begin
      next_st.done_flag = 1'b0;
      next_st.overrun   = 1'b0;
    end

    // completion wins over a read in the same cycle
    if (done_evt) begin
      next_st.rx_buf    = xfer.rx_byte;
      next_st.done_flag = 1'b1;
      if (st.done_flag && !rx_read) begin
        next_st.overrun = 1'b1;
      end
    end

    // module soft reset holds both flags clear
    if (st.soft_rst) begin
      next_st.done_flag = 1'b0;
      next_st.overrun   = 1'b0;
    end

    next_st.irq = next_st.done_flag && next_st.irq_en;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st              <= '0;
      st.waitreq      <= 1'b1;
      st.rst_hold     <= `SCB_LINK_RST_HOLD;
      st.link_rst_req <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign xfer.start_tgl = st.start_tgl;
  assign xfer.tx_byte   = st.tx_buf;
  assign xfer.transmit_output_enable      = st.transmit_output_enable;
  assign xfer.master    = st.master;

  assign avs_readdata    = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign irq             = st.irq;

  scb_shifter u_shifter (
    .link_clk   (link_clk),
    .rst        (st.link_rst_req),
    .xfer       (xfer.link),
    .sdi        (sdi),
    .sel_in_n   (sel_in_n),
    .sdo        (sdo),
    .sdo_oe     (sdo_oe),
    .sel_out_n  (sel_out_n),
    .sel_out_oe (sel_out_oe)
  );
endmodule // scb_top

/* rtl/scb_regs.svh */
// register offsets, field positions, reset values and counts of the serial control block
`ifndef SCB_REGS_SVH
`define SCB_REGS_SVH

`define SCB_ADDR_W        4
`define SCB_OFS_CTRL      4'h0
`define SCB_OFS_RXBUF     4'h4
`define SCB_OFS_TXBUF     4'h8
`define SCB_OFS_CFG       4'hC

`define SCB_BIT_IRQ_EN    0
`define SCB_BIT_TRANSMIT_OUTPUT_ENABLE      1
`define SCB_BIT_MASTER    2
`define SCB_BIT_DONE      6
`define SCB_BIT_OVERRUN   7
`define SCB_BIT_SOFT_RST  0
`define SCB_BIT_BUSY      1

`define SCB_CTRL_RESET    8'h00
`define SCB_CHAR_BITS     8
`define SCB_CNT_W         4
// core cycles the link side is held in reset, long enough for several link clock edges
`define SCB_LINK_RST_HOLD 8'h80

`endif

/* rtl/scb_pkg.sv */
// state types of the serial control block
package scb_pkg;

  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic        irq;
    logic        irq_en;
    logic        transmit_output_enable;
    logic        master;
    logic        soft_rst;
    logic        done_flag;
    logic        overrun;
    logic [7:0]  rx_buf;
    logic [7:0]  tx_buf;
    logic        start_tgl;
    logic [2:0]  done_sync;
    logic [1:0]  busy_sync;
    logic [7:0]  rst_hold;
    logic        link_rst_req;
  } scb_core_t;

  typedef enum logic [1:0] {
    SCB_IDLE  = 2'b00,
    SCB_SHIFT = 2'b01,
    SCB_END   = 2'b10
  } scb_link_state_t;

  typedef struct packed {
    scb_link_state_t state;
    logic [1:0]      transmit_output_enable_s;
    logic [1:0]      master_s;
    logic [2:0]      start_s;
    logic [1:0]      sel_s;
    logic [3:0]      cnt;
    logic [7:0]      shreg;
    logic [7:0]      rx_byte;
    logic            done_tgl;
    logic            sdo;
    logic            sdo_oe;
    logic            sel_n;
    logic            sel_oe;
  } scb_link_st_t;

endpackage

/* rtl/scb_xfer_if.sv */
// carrier between the register side and the link-side shifter
`timescale 1ns/1ns
interface scb_xfer_if;
  logic       start_tgl;
  logic [7:0] tx_byte;
  logic       transmit_output_enable;
  logic       master;
  logic       done_tgl;
  logic       busy;
  logic [7:0] rx_byte;

  modport core (output start_tgl, output tx_byte, output transmit_output_enable, output master,
                input done_tgl, input busy, input rx_byte);
  modport link (input start_tgl, input tx_byte, input transmit_output_enable, input master,
                output done_tgl, output busy, output rx_byte);
endinterface

/* rtl/scb_shifter.sv */
// link-clock shifter: one character per frame, msb first
`timescale 1ns/1ns
`include "scb_regs.svh"
module scb_shifter (
  input  wire logic link_clk,
  input  wire logic rst,
  scb_xfer_if.link  xfer,
  input  wire logic sdi,
  input  wire logic sel_in_n,
  output logic      sdo,
  output logic      sdo_oe,
  output logic      sel_out_n,
  output logic      sel_out_oe
);
  scb_pkg::scb_link_st_t st;
  scb_pkg::scb_link_st_t next_st;
  logic                  link_rst_s0;
  logic                  link_rst;

  // reset is brought over from the core domain
  always_ff @(posedge link_clk) begin
    link_rst_s0 <= rst;
    link_rst    <= link_rst_s0;
  end

  always_comb begin
    next_st          = st;
    next_st.transmit_output_enable_s   = {st.transmit_output_enable_s[0], xfer.transmit_output_enable};
    next_st.master_s = {st.master_s[0], xfer.master};
    next_st.start_s  = {st.start_s[1:0], xfer.start_tgl};
    next_st.sel_s    = {st.sel_s[0], sel_in_n};
    case (st.state)
      scb_pkg::SCB_IDLE: begin
        if ((st.master_s[1] && (st.start_s[2] != st.start_s[1])) ||
            (!st.master_s[1] && !st.sel_s[1])) begin
          next_st.state = scb_pkg::SCB_SHIFT;
          next_st.shreg = xfer.tx_byte;
          next_st.sdo   = xfer.tx_byte[7];
          next_st.cnt   = '0;
          next_st.sel_n = 1'b0;
        end
      end
      scb_pkg::SCB_SHIFT: begin
        next_st.shreg = {st.shreg[6:0], sdi};
        next_st.sdo   = st.shreg[6];
        next_st.cnt   = st.cnt + 4'h1;
        if (st.cnt == 4'(`SCB_CHAR_BITS - 1)) begin
          next_st.state    = scb_pkg::SCB_END;
          next_st.rx_byte  = {st.shreg[6:0], sdi};
          next_st.done_tgl = ~st.done_tgl;
          next_st.sel_n    = 1'b1;
        end else if (!st.master_s[1] && st.sel_s[1]) begin
          next_st.state = scb_pkg::SCB_IDLE;
        end
      end
      scb_pkg::SCB_END: begin
        // a slave waits for the select to be released (sel_in_n high) before the next character
        if (st.master_s[1] || st.sel_s[1]) begin
          next_st.state = scb_pkg::SCB_IDLE;
        end
      end
      default: next_st.state = scb_pkg::SCB_IDLE;
    endcase
    next_st.sdo_oe = st.transmit_output_enable_s[1] && (next_st.state == scb_pkg::SCB_SHIFT);
    next_st.sel_oe = st.master_s[1];
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      st       <= '0;
      st.sel_s <= 2'b11;
      st.sel_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sdo           = st.sdo;
  assign sdo_oe        = st.sdo_oe;
  assign sel_out_n     = st.sel_n;
  assign sel_out_oe    = st.sel_oe;
  assign xfer.done_tgl = st.done_tgl;
  assign xfer.rx_byte  = st.rx_byte;
  assign xfer.busy     = (st.state != scb_pkg::SCB_IDLE);
endmodule // scb_shifter

/* tb/scb_chk_checker.sv */
// port-level assertions for the serial control block
`timescale 1ns/1ns
`include "scb_regs.svh"
module scb_chk (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic [`SCB_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   irq,
  input wire logic                   sdo_oe
);
  logic [2:0] cfg;
  logic [7:0] off_cnt;
  wire        req    = avs_read || avs_write;
  wire        ctl_rd = avs_read && avs_waitrequest && avs_address == 4'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // shadow of the control bits written, and time since transmit enable went low
  always_ff @(posedge core_clk) begin
    if (rst) cfg <= 3'h0;
    else if (avs_write && avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]) cfg <= avs_writedata[2:0];
    if (rst || cfg[1]) off_cnt <= 8'h00;
    else if (off_cnt != 8'hFF) off_cnt <= off_cnt + 8'h01;
  end
  chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  chk_wait_idle: assert property (!req && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_rd_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_ctrl_rsvd: assert property (ctl_rd |=> avs_readdata[5:3] == 3'h0)
    else $error("reserved control bits not zero");
  chk_ctrl_bits: assert property (ctl_rd |=> avs_readdata[2:0] == cfg)
    else $error("control bits differ from written value");
  chk_oe_quiet: assert property (off_cnt == 8'hFF |-> !sdo_oe)
    else $error("data output driven with transmit disabled");
  chk_irq_gate: assert property (irq |-> cfg[0])
    else $error("interrupt without enable");
  chk_irq_rst: assert property (disable iff (1'b0) rst |=> !irq)
    else $error("interrupt after reset");
  chk_rx_clear: assert property (avs_read && avs_waitrequest && avs_address == 4'h4 |=> !irq)
    else $error("interrupt kept after buffer read");
  cover property ($rose(irq));
  cover property (sdo_oe && !cfg[2]);
  cover property (avs_read && avs_waitrequest && avs_address == 4'h4);
endmodule // scb_chk

bind scb_top scb_chk u_chk (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .sdo_oe(sdo_oe));

/* tb/scb_remote.sv */
// remote serial peer: slave to master frames, master of slave frames
`timescale 1ns/1ns
module scb_remote (
  input wire logic link_clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sel_out_n,
  output logic     sdi,
  output logic     sel_in_n
);
  logic       fill    = 1'b0;
  logic       armed   = 1'b0;
  logic       tog     = 1'b0;
  logic       oe_seen = 1'b0;
  logic [7:0] got     = 8'h00;
  // a released data line toggles so stale bits never pass for data
  assign sdi = armed ? fill : tog;
  initial sel_in_n = 1'b1;
  always @(posedge link_clk) begin
    tog <= ~tog;
    if (sdo_oe) oe_seen <= 1'b1;
    if (sdo_oe) got <= {got[6:0], sdo};
  end
  task automatic frame(input int bits, input logic v);
    @(posedge link_clk);
    fill <= v;
    armed <= 1'b1;
    sel_in_n <= 1'b0;
    // select is seen two link edges late and shifting starts one edge after that
    repeat (bits + 3) @(posedge link_clk);
    armed <= 1'b0;
    sel_in_n <= 1'b1;
    repeat (4) @(posedge link_clk);
  endtask
endmodule // scb_remote

/* tb/tb.sv */
// self-checking bench for the serial control block
`timescale 1ns/1ns
module tb;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, irq, sdi, sel_in_n, sdo, sdo_oe, sel_out_n, sel_out_oe;
  logic [31:0] q;
  int          bad_count = 0;
  int          compares = 0;
  always #2 core_clk = ~core_clk;
  always #40 link_clk = ~link_clk;
  scb_top DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link_clk(link_clk), .sdi(sdi), .sel_in_n(sel_in_n),
    .sdo(sdo), .sdo_oe(sdo_oe), .sel_out_n(sel_out_n), .sel_out_oe(sel_out_oe));
  scb_remote p (.link_clk(link_clk), .sdo(sdo), .sdo_oe(sdo_oe), .sel_out_n(sel_out_n), .sdi(sdi), .sel_in_n(sel_in_n));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
    check("bus answer", n, 2);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    bus(0, a, 8'h00);
    check(nm, q, {24'h0, e});
  endtask
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      bus(0, 4'h0, 8'h00);
      n++;
    end while (q[6] !== 1'b1 && n < 200);
  endtask
  task automatic send(input logic [7:0] d);
    bus(1, 4'h8, d);
    repeat (20) @(posedge link_clk);
    @(posedge core_clk);
  endtask
  task automatic t_reset();
    rd(4'h0, 8'h00, "ctrl reset");
    // the link side takes its reset a few link cycles later
    repeat (4) @(posedge link_clk);
    @(posedge core_clk);
    check("sel oe", sel_out_oe, 0);
    check("sdo oe", sdo_oe, 0);
    rd(4'h2, 8'h00, "unmapped");
    bus(1, 4'h0, 8'hFF);
    rd(4'h0, 8'h07, "ctrl rsvd");
    bus(1, 4'h0, 8'h00);
  endtask
  task automatic t_master();
    bus(1, 4'h0, 8'h06);
    p.fill = 1'b1;
    p.armed = 1'b1;
    bus(1, 4'h8, 8'hA5);
    wait_flag();
    check("ctrl done", q, 32'h46);
    check("sel oe", sel_out_oe, 1);
    check("sel idle", sel_out_n, 1);
    check("tx bits", p.got, 8'hA5);
    rd(4'h4, 8'hFF, "rx byte");
    rd(4'h0, 8'h06, "ctrl clr");
    p.fill = 1'b0;
    send(8'h5A);
    send(8'hC3);
    rd(4'h0, 8'hC6, "overrun");
    rd(4'h4, 8'h00, "rx new");
    rd(4'h0, 8'h06, "ovr clr");
    check("tx bits", p.got, 8'hC3);
    p.armed = 1'b0;
  endtask
  task automatic t_quiet();
    bus(1, 4'h0, 8'h04);
    p.oe_seen = 1'b0;
    bus(1, 4'h8, 8'h99);
    wait_flag();
    check("quiet oe", p.oe_seen, 0);
    bus(1, 4'h0, 8'h05);
    check("irq on", irq, 1);
    bus(1, 4'h0, 8'h04);
    rd(4'h0, 8'h44, "flag kept");
    check("irq off", irq, 0);
    send(8'h99);
    rd(4'h0, 8'hC4, "ovr quiet");
    bus(1, 4'hC, 8'h01);
    rd(4'h0, 8'h04, "soft rst");
    bus(1, 4'hC, 8'h00);
  endtask
  task automatic t_slave();
    bus(1, 4'h0, 8'h03);
    bus(1, 4'h8, 8'h3C);
    p.oe_seen = 1'b0;
    p.frame(8, 1'b1);
    @(posedge core_clk);
    rd(4'h0, 8'h43, "slave done");
    check("slave irq", irq, 1);
    check("slave tx", p.got, 8'h3C);
    check("slave oe", p.oe_seen, 1);
    rd(4'h4, 8'hFF, "slave rx");
    p.frame(3, 1'b0);
    @(posedge core_clk);
    rd(4'h0, 8'h03, "abort");
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    // the design stretches reset for its link side by itself
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_quiet();
    t_slave();
    print_verdict();
  end
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
endmodule // tb
